// File: design/lsc_pkg.sv
// Constants, register map and state encodings for the lane switch control block.
// Assumes a single clock domain; every user names items as lsc_pkg::name.
package lsc_pkg;

    localparam logic [7:0] REG_MASK   = 8'h00;
    localparam logic [7:0] REG_PORT_A = 8'h01;
    localparam logic [7:0] REG_PORT_B = 8'h02;
    localparam logic [7:0] REG_PORT_C = 8'h03;
    localparam logic [7:0] REG_ROUTE  = 8'h04;
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [7:0] MASK_ALL   = 8'h1f;

    // Bit positions of the source mask register.
    localparam int MSK_LOOP_A = 0;
    localparam int MSK_LOOP_B = 1;
    localparam int MSK_LOOP_C = 2;
    localparam int MSK_SEL    = 3;
    localparam int MSK_DUAL   = 4;

    // Bit positions of each per-port register.
    localparam int PORT_EMPH_LSB = 0;
    localparam int PORT_EMPH_MSB = 1;
    localparam int PORT_BOOST    = 2;
    localparam int PORT_LOOP     = 3;
    localparam int PORT_DIS      = 4;

    // Bit positions of the route control register.
    localparam int ROUTE_SEL  = 0;
    localparam int ROUTE_DUAL = 1;

    // Receive boost in dB for setting 0 and 1.
    localparam int BOOST_LOW_DB  = 6;
    localparam int BOOST_HIGH_DB = 12;

    // Emphasis settings reached from the single pin.
    localparam logic [1:0] PIN_EMPH_LOW  = 2'h0;
    localparam logic [1:0] PIN_EMPH_HIGH = 2'h2;

    // Fixed upper nibble of the seven-bit serial address.
    localparam logic [3:0] I2C_ADDR_HI = 4'h9;

    // Source code of each output.
    localparam logic [1:0] SRC_IDLE = 2'h0;
    localparam logic [1:0] SRC_IN_A = 2'h1;
    localparam logic [1:0] SRC_IN_B = 2'h2;
    localparam logic [1:0] SRC_IN_C = 2'h3;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [8:0] {
        LSC_ST_IDLE = 9'h001,
        LSC_ST_ADDR = 9'h002,
        LSC_ST_AACK = 9'h004,
        LSC_ST_REG  = 9'h008,
        LSC_ST_RACK = 9'h010,
        LSC_ST_WR   = 9'h020,
        LSC_ST_WACK = 9'h040,
        LSC_ST_RD   = 9'h080,
        LSC_ST_MACK = 9'h100
    } lsc_i2c_state_e;

endpackage

// File: design/lsc_route_decode.sv
// Combinational source decoder for the three outputs of the lane switch.
// Assumes effective controls are already chosen between pins and registers.
`timescale 1ns/10ps
`default_nettype none

module lsc_route_decode (
    input  wire logic       loop_a_i,
    input  wire logic       loop_b_i,
    input  wire logic       loop_c_i,
    input  wire logic       sel_i,
    input  wire logic       dual_i,
    input  wire logic [2:0] dis_i,
    output logic      [1:0] src_a_o,
    output logic      [1:0] src_b_o,
    output logic      [1:0] src_c_o
);

    always_comb begin
        if (dis_i[0]) begin
            src_a_o = lsc_pkg::SRC_IDLE;
        end else if (loop_a_i) begin
            src_a_o = lsc_pkg::SRC_IN_A;
        end else if (dual_i || !sel_i) begin
            src_a_o = lsc_pkg::SRC_IN_C;
        end else begin
            src_a_o = lsc_pkg::SRC_IDLE;
        end
    end

    always_comb begin
        if (dis_i[1]) begin
            src_b_o = lsc_pkg::SRC_IDLE;
        end else if (loop_b_i) begin
            src_b_o = lsc_pkg::SRC_IN_B;
        end else if (dual_i || sel_i) begin
            src_b_o = lsc_pkg::SRC_IN_C;
        end else begin
            src_b_o = lsc_pkg::SRC_IDLE;
        end
    end

    always_comb begin
        if (dis_i[2]) begin
            src_c_o = lsc_pkg::SRC_IDLE;
        end else if (loop_c_i) begin
            src_c_o = lsc_pkg::SRC_IN_C;
        end else if (sel_i) begin
            src_c_o = lsc_pkg::SRC_IN_B;
        end else begin
            src_c_o = lsc_pkg::SRC_IN_A;
        end
    end

endmodule

`default_nettype wire

// File: design/lsc_top.sv
// Lane switch control: pin synchronisers, serial register slave, control
// source selection and registered output settings for the three ports.
// Assumes control pins are asynchronous and the serial clock is slow
// compared with clk_i, so it is sampled as an ordinary input.
`timescale 1ns/10ps
`default_nettype none

module lsc_top (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       ce_i,
    input  wire logic       mode_i,
    input  wire logic       sel_pin_i,
    input  wire logic       dual_pin_i,
    input  wire logic       loop_port_a_i,
    input  wire logic       loop_port_b_i,
    input  wire logic       loop_port_c_i,
    input  wire logic       boost_a_scl_i,
    input  wire logic       boost_b_sda_i,
    input  wire logic       boost_c_pin_i,
    input  wire logic [2:0] emph_addr_pin_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    output logic      [1:0] src_a_o,
    output logic      [1:0] src_b_o,
    output logic      [1:0] src_c_o,
    output logic      [2:0] idle_o,
    output logic      [2:0] boost_o,
    output logic      [1:0] emph_a_o,
    output logic      [1:0] emph_b_o,
    output logic      [1:0] emph_c_o
);

    localparam int NPIN = 12;

    logic [NPIN-1:0]            pin_raw;
    logic [NPIN-1:0]            sync1_q;
    logic [NPIN-1:0]            sync2_q;
    logic                       mode_s;
    logic                       scl_s;
    logic                       sda_s;
    logic                       scl_d_q;
    logic                       sda_d_q;
    logic                       scl_rise;
    logic                       scl_fall;
    logic                       start_det;
    logic                       stop_det;
    lsc_pkg::lsc_i2c_state_e    state_q;
    logic [3:0]                 cnt_q;
    logic [7:0]                 shift_q;
    logic [7:0]                 tx_q;
    logic [7:0]                 ptr_q;
    logic                       rw_q;
    logic                       mack_q;
    logic                       wr_en;
    logic [4:0]                 mask_q;
    logic [4:0]                 port_q [3];
    logic [1:0]                 route_q;
    logic                       loop_a_eff;
    logic                       loop_b_eff;
    logic                       loop_c_eff;
    logic                       sel_eff;
    logic                       dual_eff;
    logic [2:0]                 dis_eff;
    logic [1:0]                 src_a_d;
    logic [1:0]                 src_b_d;
    logic [1:0]                 src_c_d;
    logic [2:0]                 boost_d;
    logic [1:0]                 emph_d [3];
    logic [6:0]                 my_addr;

    // Reads a register by offset; unmapped offsets read as zero.
    function automatic logic [7:0] rd_reg(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            lsc_pkg::REG_MASK:   v = {3'h0, mask_q};
            lsc_pkg::REG_PORT_A: v = {3'h0, port_q[0]};
            lsc_pkg::REG_PORT_B: v = {3'h0, port_q[1]};
            lsc_pkg::REG_PORT_C: v = {3'h0, port_q[2]};
            lsc_pkg::REG_ROUTE:  v = {6'h00, route_q};
            default:             v = 8'h00;
        endcase
        return v;
    endfunction

    // Picks the pin or the register copy of one switching control.
    function automatic logic pick(input logic m, input logic msk, input logic pin, input logic rg);
        return (m && msk) ? rg : pin;
    endfunction

    assign pin_raw = {mode_i, sel_pin_i, dual_pin_i, loop_port_c_i, loop_port_b_i, loop_port_a_i,
                      boost_c_pin_i, boost_b_sda_i, boost_a_scl_i, emph_addr_pin_i};

    // Two-stage synchroniser for every asynchronous pin.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce_i) begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    assign mode_s  = sync2_q[11];
    assign scl_s   = sync2_q[3];
    assign sda_s   = sync2_q[4];
    assign my_addr = {lsc_pkg::I2C_ADDR_HI, sync2_q[2:0]};

    // Edge history of the serial lines; the bus idles high.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else if (ce_i) begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
        end
    end

    assign scl_rise  = ce_i && mode_s && scl_s && !scl_d_q;
    assign scl_fall  = ce_i && mode_s && !scl_s && scl_d_q;
    assign start_det = ce_i && mode_s && scl_s && scl_d_q && !sda_s && sda_d_q;
    assign stop_det  = ce_i && mode_s && scl_s && scl_d_q && sda_s && !sda_d_q;

    // Serial slave sequencer; in pin mode the serial pins are controls and it stays idle.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= lsc_pkg::LSC_ST_IDLE;
        end else if (ce_i) begin
            if (!mode_s || stop_det) begin
                state_q <= lsc_pkg::LSC_ST_IDLE;
            end else if (start_det) begin
                state_q <= lsc_pkg::LSC_ST_ADDR;
            end else if (scl_fall) begin
                case (state_q)
                    lsc_pkg::LSC_ST_ADDR: begin
                        if (cnt_q == lsc_pkg::BITS_PER_BYTE) begin
                            state_q <= (shift_q[7:1] == my_addr) ? lsc_pkg::LSC_ST_AACK
                                                                 : lsc_pkg::LSC_ST_IDLE;
                        end
                    end
                    lsc_pkg::LSC_ST_AACK: state_q <= rw_q ? lsc_pkg::LSC_ST_RD : lsc_pkg::LSC_ST_REG;
                    lsc_pkg::LSC_ST_REG: begin
                        if (cnt_q == lsc_pkg::BITS_PER_BYTE) begin
                            state_q <= lsc_pkg::LSC_ST_RACK;
                        end
                    end
                    lsc_pkg::LSC_ST_RACK: state_q <= lsc_pkg::LSC_ST_WR;
                    lsc_pkg::LSC_ST_WR: begin
                        if (cnt_q == lsc_pkg::BITS_PER_BYTE) begin
                            state_q <= lsc_pkg::LSC_ST_WACK;
                        end
                    end
                    lsc_pkg::LSC_ST_WACK: state_q <= lsc_pkg::LSC_ST_WR;
                    lsc_pkg::LSC_ST_RD: begin
                        if (cnt_q == lsc_pkg::BITS_PER_BYTE) begin
                            state_q <= lsc_pkg::LSC_ST_MACK;
                        end
                    end
                    lsc_pkg::LSC_ST_MACK: state_q <= mack_q ? lsc_pkg::LSC_ST_RD : lsc_pkg::LSC_ST_IDLE;
                    default: state_q <= lsc_pkg::LSC_ST_IDLE;
                endcase
            end
        end
    end

    // Bit counter and receive shifter: bits are sampled on the serial clock rise.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
            mack_q  <= 1'b0;
        end else if (ce_i) begin
            if (start_det || (scl_fall && cnt_q == lsc_pkg::BITS_PER_BYTE)) begin
                cnt_q <= 4'h0;
            end else if (scl_rise && (state_q == lsc_pkg::LSC_ST_ADDR || state_q == lsc_pkg::LSC_ST_REG ||
                                      state_q == lsc_pkg::LSC_ST_WR || state_q == lsc_pkg::LSC_ST_RD)) begin
                cnt_q   <= cnt_q + 4'h1;
                shift_q <= {shift_q[6:0], sda_s};
            end
            if (scl_rise && state_q == lsc_pkg::LSC_ST_MACK) begin
                mack_q <= !sda_s;
            end
        end
    end

    // Direction bit, register pointer and transmit shifter.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rw_q  <= 1'b0;
            ptr_q <= 8'h00;
            tx_q  <= 8'h00;
        end else if (ce_i && scl_fall) begin
            if (state_q == lsc_pkg::LSC_ST_ADDR && cnt_q == lsc_pkg::BITS_PER_BYTE) begin
                rw_q <= shift_q[0];
            end
            if (state_q == lsc_pkg::LSC_ST_REG && cnt_q == lsc_pkg::BITS_PER_BYTE) begin
                ptr_q <= shift_q;
            end
            if ((state_q == lsc_pkg::LSC_ST_AACK && rw_q) || (state_q == lsc_pkg::LSC_ST_MACK && mack_q)) begin
                tx_q <= rd_reg(ptr_q);
            end else if (state_q == lsc_pkg::LSC_ST_RD) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // Open-drain data line: low during acknowledge or a zero read bit.
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = !(state_q == lsc_pkg::LSC_ST_AACK || state_q == lsc_pkg::LSC_ST_RACK ||
                          state_q == lsc_pkg::LSC_ST_WACK ||
                          (state_q == lsc_pkg::LSC_ST_RD && !tx_q[7]));

    assign wr_en = scl_fall && state_q == lsc_pkg::LSC_ST_WR && cnt_q == lsc_pkg::BITS_PER_BYTE;

    // Register file; the reset pin clears every register.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask_q    <= lsc_pkg::REG_RESET[4:0];
            port_q[0] <= lsc_pkg::REG_RESET[4:0];
            port_q[1] <= lsc_pkg::REG_RESET[4:0];
            port_q[2] <= lsc_pkg::REG_RESET[4:0];
            route_q   <= lsc_pkg::REG_RESET[1:0];
        end else if (ce_i && wr_en) begin
            case (ptr_q)
                lsc_pkg::REG_MASK:   mask_q    <= shift_q[4:0];
                lsc_pkg::REG_PORT_A: port_q[0] <= shift_q[4:0];
                lsc_pkg::REG_PORT_B: port_q[1] <= shift_q[4:0];
                lsc_pkg::REG_PORT_C: port_q[2] <= shift_q[4:0];
                lsc_pkg::REG_ROUTE:  route_q   <= shift_q[1:0];
                default: ;
            endcase
        end
    end

    // Effective switching controls from pins or registers.
    assign loop_a_eff = pick(mode_s, mask_q[lsc_pkg::MSK_LOOP_A], sync2_q[6],
                             port_q[0][lsc_pkg::PORT_LOOP]);
    assign loop_b_eff = pick(mode_s, mask_q[lsc_pkg::MSK_LOOP_B], sync2_q[7],
                             port_q[1][lsc_pkg::PORT_LOOP]);
    assign loop_c_eff = pick(mode_s, mask_q[lsc_pkg::MSK_LOOP_C], sync2_q[8],
                             port_q[2][lsc_pkg::PORT_LOOP]);
    assign sel_eff    = pick(mode_s, mask_q[lsc_pkg::MSK_SEL], sync2_q[10],
                             route_q[lsc_pkg::ROUTE_SEL]);
    assign dual_eff   = pick(mode_s, mask_q[lsc_pkg::MSK_DUAL], sync2_q[9],
                             route_q[lsc_pkg::ROUTE_DUAL]);
    assign dis_eff    = mode_s ? {port_q[2][lsc_pkg::PORT_DIS], port_q[1][lsc_pkg::PORT_DIS],
                                  port_q[0][lsc_pkg::PORT_DIS]} : 3'h0;

    lsc_route_decode u_decode (
        .loop_a_i (loop_a_eff),
        .loop_b_i (loop_b_eff),
        .loop_c_i (loop_c_eff),
        .sel_i    (sel_eff),
        .dual_i   (dual_eff),
        .dis_i    (dis_eff),
        .src_a_o  (src_a_d),
        .src_b_o  (src_b_d),
        .src_c_o  (src_c_d)
    );

    // Boost and emphasis per port: pins in pin mode, registers otherwise.
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            if (mode_s) begin
                boost_d[p] = port_q[p][lsc_pkg::PORT_BOOST];
                emph_d[p]  = port_q[p][lsc_pkg::PORT_EMPH_MSB:lsc_pkg::PORT_EMPH_LSB];
            end else begin
                boost_d[p] = sync2_q[3+p];
                emph_d[p]  = sync2_q[p] ? lsc_pkg::PIN_EMPH_HIGH : lsc_pkg::PIN_EMPH_LOW;
            end
        end
    end

    // Output settings re-registered every enabled cycle.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            src_a_o  <= lsc_pkg::SRC_IDLE;
            src_b_o  <= lsc_pkg::SRC_IDLE;
            src_c_o  <= lsc_pkg::SRC_IDLE;
            idle_o   <= 3'h7;
            boost_o  <= 3'h0;
            emph_a_o <= 2'h0;
            emph_b_o <= 2'h0;
            emph_c_o <= 2'h0;
        end else if (ce_i) begin
            src_a_o  <= src_a_d;
            src_b_o  <= src_b_d;
            src_c_o  <= src_c_d;
            idle_o   <= {src_c_d == lsc_pkg::SRC_IDLE, src_b_d == lsc_pkg::SRC_IDLE,
                         src_a_d == lsc_pkg::SRC_IDLE};
            boost_o  <= boost_d;
            emph_a_o <= emph_d[0];
            emph_b_o <= emph_d[1];
            emph_c_o <= emph_d[2];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_mux_output_c: assert property (ce_i && !loop_c_eff && !dis_eff[2] |=>
        src_c_o == ($past(sel_eff) ? lsc_pkg::SRC_IN_B : lsc_pkg::SRC_IN_A))
        else $error("output C source wrong");

    a_demux_single: assert property (ce_i && !loop_a_eff && !loop_b_eff && !dual_eff && dis_eff == 3'h0 |=>
        (src_a_o == ($past(sel_eff) ? lsc_pkg::SRC_IDLE : lsc_pkg::SRC_IN_C)) &&
        (src_b_o == ($past(sel_eff) ? lsc_pkg::SRC_IN_C : lsc_pkg::SRC_IDLE)))
        else $error("single route wrong");

    a_dual_both: assert property (ce_i && dual_eff && !loop_a_eff && !loop_b_eff && dis_eff[1:0] == 2'h0 |=>
        src_a_o == lsc_pkg::SRC_IN_C && src_b_o == lsc_pkg::SRC_IN_C)
        else $error("dual-cast did not drive both outputs");

    a_loop_own: assert property (ce_i && loop_b_eff && !loop_a_eff && dis_eff == 3'h0 |=>
        src_b_o == lsc_pkg::SRC_IN_B &&
        src_a_o == (($past(dual_eff) || !$past(sel_eff)) ? lsc_pkg::SRC_IN_C : lsc_pkg::SRC_IDLE))
        else $error("loopback override wrong");

    a_disable_idle: assert property (ce_i && mode_s && port_q[0][lsc_pkg::PORT_DIS] |=>
        src_a_o == lsc_pkg::SRC_IDLE && idle_o[0])
        else $error("disabled output not idle");

    a_pin_no_disable: assert property (ce_i && !mode_s && !loop_a_eff && !sel_eff |=>
        src_a_o == lsc_pkg::SRC_IN_C && !idle_o[0])
        else $error("pin mode output disabled");

    a_pin_emph_map: assert property (ce_i && !mode_s |=>
        emph_c_o == ($past(sync2_q[2]) ? lsc_pkg::PIN_EMPH_HIGH : lsc_pkg::PIN_EMPH_LOW) &&
        boost_o[2] == $past(sync2_q[5]))
        else $error("pin mode emphasis or boost wrong");

    a_reg_boost: assert property (ce_i && mode_s |=>
        boost_o[1] == $past(port_q[1][lsc_pkg::PORT_BOOST]) &&
        emph_b_o == $past(port_q[1][lsc_pkg::PORT_EMPH_MSB:lsc_pkg::PORT_EMPH_LSB]))
        else $error("register boost or emphasis not used");

    a_mask_source: assert property (mode_s |->
        sel_eff == (mask_q[lsc_pkg::MSK_SEL] ? route_q[lsc_pkg::ROUTE_SEL] : sync2_q[10]) &&
        loop_c_eff == (mask_q[lsc_pkg::MSK_LOOP_C] ? port_q[2][lsc_pkg::PORT_LOOP] : sync2_q[8]))
        else $error("mask source selection wrong");

    sequence s_addr_byte_done;
        state_q == lsc_pkg::LSC_ST_ADDR && cnt_q == lsc_pkg::BITS_PER_BYTE && scl_fall &&
        !stop_det && !start_det && mode_s;
    endsequence

    sequence s_ack_driven;
        state_q == lsc_pkg::LSC_ST_AACK && !sda_oe_n_o;
    endsequence

    a_addr_ack: assert property (s_addr_byte_done ##0 (shift_q[7:1] == my_addr) |=> s_ack_driven)
        else $error("own address not acknowledged");

    a_addr_ignore: assert property (s_addr_byte_done ##0 (shift_q[7:1] != my_addr) |=>
        state_q == lsc_pkg::LSC_ST_IDLE && sda_oe_n_o)
        else $error("foreign address acknowledged");

    a_pin_mode_quiet: assert property (!mode_s |=> state_q == lsc_pkg::LSC_ST_IDLE && sda_oe_n_o)
        else $error("serial slave active in pin mode");

endmodule

`default_nettype wire

// File: dv/lsc_master_model.sv
// Serial bus master and data line pull-up for the lane switch registers.
// Assumes the bench holds the mode pin high while a transfer runs.
`timescale 1ns/10ps
`default_nettype none

module lsc_master_model (
    input  wire logic clk_i,
    input  wire logic sda_oe_n_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic pull_low = 1'b0;

    // The data line has a pull-up, so it is high unless a party pulls it.
    assign sda_o = !(pull_low || !sda_oe_n_i);
    initial scl_o = 1'b1;

    task automatic gap();
        repeat (6) @(negedge clk_i);
    endtask

    task automatic bitx(input logic b, output logic r);
        gap();
        pull_low = !b;
        gap();
        scl_o = 1'b1;
        gap();
        r = sda_o;
        scl_o = 1'b0;
    endtask

    task automatic start();
        pull_low = 1'b0;
        gap();
        scl_o = 1'b1;
        gap();
        pull_low = 1'b1;
        gap();
        scl_o = 1'b0;
    endtask

    task automatic stop();
        gap();
        pull_low = 1'b1;
        gap();
        scl_o = 1'b1;
        gap();
        pull_low = 1'b0;
        gap();
    endtask

    // The ninth bit is always released, so a read byte ends in a refusal.
    task automatic byte_x(input logic [7:0] d, output logic [7:0] r, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r[i]);
        end
        bitx(1'b1, nak);
    endtask

    task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic nak);
        logic [7:0] r;
        logic       n1, n2, n3;
        start();
        byte_x({dev, 1'b0}, r, n1);
        byte_x(a, r, n2);
        byte_x(d, r, n3);
        stop();
        nak = n1 | n2 | n3;
    endtask

    task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d, output logic nak);
        logic [7:0] r;
        logic       n1, n2, n3, n4;
        start();
        byte_x({dev, 1'b0}, r, n1);
        byte_x(a, r, n2);
        start();
        byte_x({dev, 1'b1}, r, n3);
        byte_x(8'hff, d, n4);
        stop();
        nak = n1 | n2 | n3;
    endtask
endmodule

`default_nettype wire

// File: dv/test_lsc_top.sv
// Self-checking bench for the lane switch control block.
// Assumes the serial master model and the package are compiled first.
`timescale 1ns/10ps
`default_nettype none

module test_lsc_top;
    localparam logic [2:0] ADR_LO = 3'h5;
    logic clk, resetn = 1'b0, mode = 1'b0, sel = 1'b0, dual = 1'b0;
    logic la = 1'b0, lb = 1'b0, lc = 1'b0, pa = 1'b1, pb = 1'b1, pc = 1'b0;
    logic [2:0]  pe = 3'h0;
    logic [31:0] lfsr = 32'he28f924b;
    logic [7:0]  shd [0:7] = '{default: 8'h00};
    logic [7:0]  d;
    logic        nak, scl, sda, oe_n;
    logic        ce = 1'b1;
    logic [5:0]  last_s;
    logic [1:0]  src_a, src_b, src_c, em_a, em_b, em_c;
    logic [2:0]  idle, bst;
    int          n_mismatch = 0, checks = 0;

    lsc_master_model u_mst (.clk_i(clk), .sda_oe_n_i(oe_n), .scl_o(scl), .sda_o(sda));
    lsc_top dut (.clk_i(clk), .resetn_i(resetn), .ce_i(ce), .mode_i(mode), .sel_pin_i(sel),
        .dual_pin_i(dual), .loop_port_a_i(la), .loop_port_b_i(lb), .loop_port_c_i(lc),
        .boost_a_scl_i(mode ? scl : pa), .boost_b_sda_i(mode ? sda : pb), .boost_c_pin_i(pc),
        .emph_addr_pin_i(pe), .sda_o(), .sda_oe_n_o(oe_n), .src_a_o(src_a), .src_b_o(src_b),
        .src_c_o(src_c), .idle_o(idle), .boost_o(bst), .emph_a_o(em_a), .emph_b_o(em_b),
        .emph_c_o(em_c));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Controls arrive as {dual, sel, loop c, loop b, loop a}; result is {c, b, a}.
    function automatic logic [5:0] exp_src(input logic [4:0] c, input logic [2:0] dis);
        logic [1:0] a, b, o;
        a = c[0] ? lsc_pkg::SRC_IN_A : (!c[3] || c[4]) ? lsc_pkg::SRC_IN_C : lsc_pkg::SRC_IDLE;
        b = c[1] ? lsc_pkg::SRC_IN_B : (c[3] || c[4]) ? lsc_pkg::SRC_IN_C : lsc_pkg::SRC_IDLE;
        o = c[2] ? lsc_pkg::SRC_IN_C : c[3] ? lsc_pkg::SRC_IN_B : lsc_pkg::SRC_IN_A;
        return {dis[2] ? lsc_pkg::SRC_IDLE : o, dis[1] ? lsc_pkg::SRC_IDLE : b, dis[0] ? lsc_pkg::SRC_IDLE : a};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic w(input logic [7:0] a, input logic [7:0] v);
        u_mst.wr({lsc_pkg::I2C_ADDR_HI, ADR_LO}, a, v, nak);
        chk({7'h0, nak}, 8'h00);
        if (a < 8'h05) shd[a] = v & ((a == 8'h04) ? 8'h03 : 8'h1f);
    endtask

    task automatic step();
        logic [4:0] c;
        logic [5:0] s;
        lfsr = nxt(lfsr);
        {dual, sel, lc, lb, la, pc} = lfsr[5:0];
        if (!mode) {pa, pb, pe} = lfsr[10:6];
        repeat (4) @(negedge clk);
        c = {dual, sel, lc, lb, la};
        if (mode) c = (shd[0][4:0] & {shd[4][1:0], shd[3][3], shd[2][3], shd[1][3]}) | (~shd[0][4:0] & c);
        s = exp_src(c, mode ? {shd[3][4], shd[2][4], shd[1][4]} : 3'h0);
        last_s = s;
        chk({2'h0, src_c, src_b, src_a}, {2'h0, s});
        chk({5'h0, idle}, {5'h0, s[5:4] == 2'h0, s[3:2] == 2'h0, s[1:0] == 2'h0});
        chk({5'h0, bst}, mode ? {5'h0, shd[3][2], shd[2][2], shd[1][2]} : {5'h0, pc, pb, pa});
        chk({2'h0, em_c, em_b, em_a}, mode ? {2'h0, shd[3][1:0], shd[2][1:0], shd[1][1:0]}
            : {2'h0, pe[2], 1'b0, pe[1], 1'b0, pe[0], 1'b0});
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (5) @(negedge clk);
        chk({5'h0, idle}, 8'h07);
        resetn = 1'b1;
        repeat (24) step();
        pa = 1'b1;
        pb = 1'b1;
        pe = ADR_LO;
        mode = 1'b1;
        repeat (10) @(negedge clk);
        u_mst.wr({lsc_pkg::I2C_ADDR_HI, ~ADR_LO}, 8'h00, 8'h1f, nak);
        chk({7'h0, nak}, 8'h01);
        step();
        for (int k = 0; k < 8; k++) begin
            lfsr = nxt(lfsr);
            w(8'h00, (k == 0) ? lsc_pkg::MASK_ALL : (k == 1) ? 8'h0c : {3'h0, lfsr[4:0]});
            for (int a = 1; a < 5; a++) w(a[7:0], lfsr[(a - 1) * 8 +: 8]);
            step();
        end
        w(8'h07, 8'h55);
        for (int a = 0; a < 8; a++) begin
            u_mst.rd({lsc_pkg::I2C_ADDR_HI, ADR_LO}, a[7:0], d, nak);
            chk(d, shd[a]);
        end
        mode = 1'b0;
        repeat (16) step();
        // With the clock enable low the outputs must hold while the pins move.
        ce = 1'b0;
        {dual, sel} = ~{dual, sel};
        repeat (4) @(negedge clk);
        chk({2'h0, src_c, src_b, src_a}, {2'h0, last_s});
        ce = 1'b1;
        step();
        final_report();
    end
endmodule

`default_nettype wire
